// ===== rtl/ccfc_pkg.sv
package ccfc_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned DISP_FAST_HZ  = 10;
  localparam int unsigned DISP_SLOW_HZ  = 4;
  localparam int unsigned PEAK_LO_HZ    = 10;
  localparam int unsigned PEAK_MID_HZ   = 100;
  localparam int unsigned PEAK_HI_HZ    = 1_000;
  localparam int unsigned PEAK_MAX_HZ   = 10_000;
  localparam int unsigned DISP_FAST_CYC = CLK_HZ / DISP_FAST_HZ;
  localparam int unsigned DISP_SLOW_CYC = CLK_HZ / DISP_SLOW_HZ;
  localparam int unsigned PEAK_LO_CYC   = CLK_HZ / PEAK_LO_HZ;
  localparam int unsigned PEAK_MID_CYC  = CLK_HZ / PEAK_MID_HZ;
  localparam int unsigned PEAK_HI_CYC   = CLK_HZ / PEAK_HI_HZ;
  localparam int unsigned PEAK_MAX_CYC  = CLK_HZ / PEAK_MAX_HZ;

  localparam int unsigned FORCE_W   = 24;
  localparam int unsigned RES_DEPTH = 100;
  localparam int unsigned RES_AW    = 7;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_LIMA    = 8'h08;
  localparam logic [7:0] ADDR_LIMB    = 8'h0c;
  localparam logic [7:0] ADDR_DISP    = 8'h10;
  localparam logic [7:0] ADDR_TPEAK   = 8'h14;
  localparam logic [7:0] ADDR_CPEAK   = 8'h18;
  localparam logic [7:0] ADDR_CAPT    = 8'h1c;
  localparam logic [7:0] ADDR_INTST   = 8'h20;
  localparam logic [7:0] ADDR_INTMSK  = 8'h24;
  localparam logic [7:0] ADDR_RESIDX  = 8'h28;
  localparam logic [7:0] ADDR_RESDATA = 8'h2c;
  localparam logic [7:0] ADDR_CMD     = 8'h30;

  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_CLOSE    = 1;
  localparam int unsigned CTRL_MODE     = 2;
  localparam int unsigned CTRL_PF       = 3;
  localparam int unsigned CTRL_NOM      = 4;
  localparam int unsigned CTRL_SLOW     = 5;
  localparam int unsigned CTRL_RATE_LSB = 6;
  localparam int unsigned CTRL_UNIT_LSB = 8;
  localparam int unsigned CTRL_W        = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h0c0;

  localparam int unsigned CMD_REARM  = 0;
  localparam int unsigned CMD_CLRPK  = 1;
  localparam int unsigned CMD_CLRRES = 2;

  localparam int unsigned INT_CAP  = 0;
  localparam int unsigned INT_FAIL = 1;
  localparam int unsigned INT_FULL = 2;
  localparam int unsigned INT_W    = 3;

  localparam int unsigned STAT_FROZEN = 0;
  localparam int unsigned STAT_ARMED  = 1;
  localparam int unsigned STAT_PASS   = 2;
  localparam int unsigned STAT_FAIL   = 3;
  localparam int unsigned STAT_DET    = 4;
  localparam int unsigned STAT_FULL   = 5;
  localparam int unsigned STAT_CNT    = 8;

  localparam logic [1:0] RATE_LO  = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_HI  = 2'h2;
  localparam logic [1:0] RATE_MAX = 2'h3;

  localparam int unsigned DISP_SH_FAST = 2;
  localparam int unsigned DISP_SH_SLOW = 4;

  typedef enum logic [1:0] {CAP_IDLE, CAP_ARMED, CAP_FROZEN} ccfc_cap_t;
endpackage

// ===== rtl/ccfc_tick_if.sv
interface ccfc_tick_if;
  logic [31:0] period;
  logic        tick;
  modport gen  (input period, output tick);
  modport user (output period, input tick);
endinterface

// ===== rtl/ccfc_tick_gen.sv
module ccfc_tick_gen (
  input logic       ref_clk,
  input logic       srst,
  ccfc_tick_if.gen  tk
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } ccfc_tick_st_t;

  ccfc_tick_st_t s_q;
  ccfc_tick_st_t s_d;

  assign tk.tick = s_q.tick;

  // >= so a shortened period fires at once instead of wrapping
  always_comb begin
    s_d = s_q;
    if (s_q.cnt >= tk.period - 32'h1) begin
      s_d.cnt  = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt  = s_q.cnt + 32'h1;
      s_d.tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== rtl/ccfc_contact_capture.sv
// Operation
// - in open-type capture a high-to-low change of the detect input triggers a capture.
// - in close-type capture a low-to-high change of the detect input triggers a capture.
// - a capture holds the displayed value at the force present at the change and stops updates.
// - with contact closure disabled nothing freezes and the capture mode is not available.
// - in capture mode an indicator tells an open-type setup from a close-type setup.
// - with pass/fail on, the frozen load is checked against a range or a nominal with band.
// - captured results go to result memory for later statistics and units stay selectable.
// - the instantaneous display updates at 10 Hz by default, or 4 Hz with more averaging.
// - the peak filter feeds only the tension and compression peaks, not the display path.
// - the peak filter rate is selectable as 10 Hz, 100 Hz, 1 kHz or the 10 kHz maximum.
// - the peak filter rate starts at 10 kHz after reset.
module ccfc_contact_capture
  import ccfc_pkg::*;
#(
  parameter int unsigned DISP_FAST_P = DISP_FAST_CYC,
  parameter int unsigned DISP_SLOW_P = DISP_SLOW_CYC,
  parameter int unsigned PEAK_LO_P   = PEAK_LO_CYC,
  parameter int unsigned PEAK_MID_P  = PEAK_MID_CYC,
  parameter int unsigned PEAK_HI_P   = PEAK_HI_CYC,
  parameter int unsigned PEAK_MAX_P  = PEAK_MAX_CYC
) (
  input  logic                      ref_clk,
  input  logic                      srst,
  input  logic                      psel,
  input  logic                      penable,
  input  logic                      pwrite,
  input  logic [7:0]                paddr,
  input  logic [31:0]               pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  logic                      detectIn,
  input  logic signed [FORCE_W-1:0] forceIn,
  input  logic                      forceValid,
  output logic signed [FORCE_W-1:0] dispValue,
  output logic signed [FORCE_W-1:0] tensionPeak,
  output logic signed [FORCE_W-1:0] compressionPeak,
  output logic                      captureFrozen,
  output logic                      open_capture_indicator,
  output logic                      close_capture_indicator,
  output logic                      passFlag,
  output logic                      failFlag,
  output logic [1:0]                unitsSel,
  output logic                      irq
);
  typedef struct packed {
    logic [2:0]                detSync;
    logic                      detLvl;
    ccfc_cap_t                 cap;
    logic                      modeAct;
    logic [CTRL_W-1:0]         ctrl;
    logic signed [FORCE_W-1:0] lastF;
    logic signed [FORCE_W-1:0] dispF;
    logic signed [FORCE_W-1:0] captF;
    logic signed [FORCE_W-1:0] dispOut;
    logic signed [FORCE_W-1:0] peakS;
    logic signed [FORCE_W-1:0] tPeak;
    logic signed [FORCE_W-1:0] cPeak;
    logic signed [FORCE_W-1:0] limA;
    logic signed [FORCE_W-1:0] limB;
    logic [INT_W-1:0]          intSt;
    logic [INT_W-1:0]          intMsk;
    logic [RES_AW-1:0]         resCnt;
    logic [RES_AW-1:0]         resIdx;
    logic [31:0]               prdata;
    logic                      pslverr;
    logic                      passF;
    logic                      failF;
    logic                      openInd;
    logic                      closeInd;
    logic                      irq;
  } ccfc_top_st_t;

  ccfc_top_st_t s_q;
  ccfc_top_st_t s_d;

  logic signed [FORCE_W-1:0] resMem [RES_DEPTH];
  logic [FORCE_W-1:0]        resRd;
  logic                      memWe;

  ccfc_tick_if dispIf ();
  ccfc_tick_if peakIf ();

  ccfc_tick_gen u_disp_tick (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tk      (dispIf.gen)
  );

  ccfc_tick_gen u_peak_tick (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tk      (peakIf.gen)
  );

  logic                 active;
  logic                 detStable;
  logic                 detRise;
  logic                 detFall;
  logic                 capEvt;
  logic                 pfOk;
  logic                 memFull;
  logic                 wrAcc;
  logic                 rdSetup;
  logic [INT_W-1:0]     evts;
  logic signed [24:0]   dd;
  logic signed [24:0]   ddSh;
  logic signed [24:0]   nomDiff;
  logic signed [24:0]   peakSum;
  logic signed [FORCE_W-1:0] peakF;

  assign pready  = 1'b1;
  assign prdata  = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign wrAcc   = psel & penable & pwrite;
  assign rdSetup = psel & ~penable;
  assign active  = s_q.ctrl[CTRL_EN] & s_q.ctrl[CTRL_MODE];
  assign memFull = (s_q.resCnt == RES_AW'(RES_DEPTH));

  // second and third stages must agree before the level moves
  assign detStable = (s_q.detSync[1] == s_q.detSync[2]);
  assign detRise   = detStable & s_q.detSync[2] & ~s_q.detLvl;
  assign detFall   = detStable & ~s_q.detSync[2] & s_q.detLvl;
  assign capEvt    = active & (s_q.cap == CAP_ARMED) &
                     (s_q.ctrl[CTRL_CLOSE] ? detRise : detFall);

  assign dispIf.period = s_q.ctrl[CTRL_SLOW] ? DISP_SLOW_P : DISP_FAST_P;
  always_comb begin
    unique case (s_q.ctrl[CTRL_RATE_LSB +: 2])
      RATE_LO:  peakIf.period = PEAK_LO_P;
      RATE_MID: peakIf.period = PEAK_MID_P;
      RATE_HI:  peakIf.period = PEAK_HI_P;
      RATE_MAX: peakIf.period = PEAK_MAX_P;
    endcase
  end

  // range: limA..limB, nominal: |force - limA| <= limB
  always_comb begin
    nomDiff = {s_q.lastF[FORCE_W-1], s_q.lastF} - {s_q.limA[FORCE_W-1], s_q.limA};
    if (nomDiff < 0) begin
      nomDiff = -nomDiff;
    end
    if (s_q.ctrl[CTRL_NOM]) begin
      pfOk = (nomDiff <= 25'(s_q.limB));
    end else begin
      pfOk = (s_q.lastF >= s_q.limA) && (s_q.lastF <= s_q.limB);
    end
  end

  assign dd      = {s_q.lastF[FORCE_W-1], s_q.lastF} - {s_q.dispF[FORCE_W-1], s_q.dispF};
  assign ddSh    = dd >>> (s_q.ctrl[CTRL_SLOW] ? DISP_SH_SLOW : DISP_SH_FAST);
  // two-tap average at the chosen rate; cheap, adds half a tick of lag at every rate
  assign peakSum = {s_q.peakS[FORCE_W-1], s_q.peakS} + {s_q.lastF[FORCE_W-1], s_q.lastF};
  assign peakF   = peakSum[FORCE_W:1];
  assign memWe   = capEvt & ~memFull;

  always_comb begin
    s_d = s_q;
    evts = '0;
    s_d.detSync = {s_q.detSync[1:0], detectIn};
    if (detStable) begin
      s_d.detLvl = s_q.detSync[2];
    end
    if (forceValid) begin
      s_d.lastF = forceIn;
    end
    s_d.modeAct = active;

    unique case (s_q.cap)
      CAP_IDLE: begin
        if (active & ~s_q.modeAct) begin
          s_d.cap = CAP_ARMED;
        end
      end
      CAP_ARMED: begin
        if (capEvt) begin
          s_d.cap   = CAP_FROZEN;
          s_d.captF = s_q.lastF;
          s_d.passF = s_q.ctrl[CTRL_PF] & pfOk;
          s_d.failF = s_q.ctrl[CTRL_PF] & ~pfOk;
          evts[INT_CAP]  = 1'b1;
          evts[INT_FAIL] = s_q.ctrl[CTRL_PF] & ~pfOk;
          evts[INT_FULL] = memFull;
        end
      end
      CAP_FROZEN: s_d.cap = CAP_FROZEN;
      default:    s_d.cap = CAP_IDLE;
    endcase
    if (memWe) begin
      s_d.resCnt = s_q.resCnt + RES_AW'(1);
    end

    if (dispIf.tick) begin
      s_d.dispF = s_q.dispF + ddSh[FORCE_W-1:0];
    end
    if (peakIf.tick) begin
      s_d.peakS = s_q.lastF;
      if (peakF > s_q.tPeak) begin
        s_d.tPeak = peakF;
      end
      if (peakF < s_q.cPeak) begin
        s_d.cPeak = peakF;
      end
    end

    s_d.pslverr = 1'b0;
    s_d.prdata  = '0;
    if (rdSetup) begin
      unique case (paddr)
        ADDR_CTRL:    s_d.prdata = 32'(s_q.ctrl);
        ADDR_STATUS:  s_d.prdata = {17'h0, s_q.resCnt, 2'h0, memFull, s_q.detLvl,
                                    s_q.failF, s_q.passF,
                                    s_q.cap == CAP_ARMED, s_q.cap == CAP_FROZEN};
        ADDR_LIMA:    s_d.prdata = 32'(s_q.limA);
        ADDR_LIMB:    s_d.prdata = 32'(s_q.limB);
        ADDR_DISP:    s_d.prdata = 32'(s_q.dispOut);
        ADDR_TPEAK:   s_d.prdata = 32'(s_q.tPeak);
        ADDR_CPEAK:   s_d.prdata = 32'(s_q.cPeak);
        ADDR_CAPT:    s_d.prdata = 32'(s_q.captF);
        ADDR_INTST:   s_d.prdata = 32'(s_q.intSt);
        ADDR_INTMSK:  s_d.prdata = 32'(s_q.intMsk);
        ADDR_RESIDX:  s_d.prdata = 32'(s_q.resIdx);
        ADDR_RESDATA: s_d.prdata = 32'(resRd);
        ADDR_CMD:     s_d.prdata = 32'h0;
        default:      s_d.pslverr = 1'b1;
      endcase
    end else if (psel & penable) begin
      s_d.prdata  = s_q.prdata;
      s_d.pslverr = s_q.pslverr;
    end

    s_d.intSt = s_q.intSt;
    if (wrAcc) begin
      unique case (paddr)
        ADDR_CTRL:   s_d.ctrl   = pwdata[CTRL_W-1:0];
        ADDR_LIMA:   s_d.limA   = pwdata[FORCE_W-1:0];
        ADDR_LIMB:   s_d.limB   = pwdata[FORCE_W-1:0];
        ADDR_INTST:  s_d.intSt  = s_q.intSt & ~pwdata[INT_W-1:0];
        ADDR_INTMSK: s_d.intMsk = pwdata[INT_W-1:0];
        ADDR_RESIDX: s_d.resIdx = pwdata[RES_AW-1:0];
        ADDR_CMD: begin
          if (pwdata[CMD_REARM] & active & ~capEvt) begin
            s_d.cap   = CAP_ARMED;
            s_d.passF = 1'b0;
            s_d.failF = 1'b0;
          end
          if (pwdata[CMD_CLRPK]) begin
            s_d.tPeak = '0;
            s_d.cPeak = '0;
          end
          if (pwdata[CMD_CLRRES]) begin
            s_d.resCnt = '0;
          end
        end
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle clear
    s_d.intSt = s_d.intSt | evts;

    if (!active) begin
      s_d.cap   = CAP_IDLE;
      s_d.passF = 1'b0;
      s_d.failF = 1'b0;
    end
    s_d.dispOut  = (s_d.cap == CAP_FROZEN) ? s_d.captF : s_d.dispF;
    s_d.openInd  = active & ~s_d.ctrl[CTRL_CLOSE];
    s_d.closeInd = active & s_d.ctrl[CTRL_CLOSE];
    s_d.irq      = |(s_d.intSt & s_d.intMsk);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q      <= '0;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // limitation: a full memory drops further results until cleared
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      resMem[s_q.resCnt] <= s_q.lastF;
    end
  end
  assign resRd = (s_q.resIdx < RES_AW'(RES_DEPTH)) ? resMem[s_q.resIdx] : '0;

  assign dispValue               = s_q.dispOut;
  assign tensionPeak             = s_q.tPeak;
  assign compressionPeak         = s_q.cPeak;
  assign captureFrozen           = (s_q.cap == CAP_FROZEN);
  assign open_capture_indicator  = s_q.openInd;
  assign close_capture_indicator = s_q.closeInd;
  assign passFlag                = s_q.passF;
  assign failFlag                = s_q.failF;
  assign unitsSel                = s_q.ctrl[CTRL_UNIT_LSB +: 2];
  assign irq                     = s_q.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [31:0] dispGap;
  always_ff @(posedge ref_clk) begin
    if (srst || dispIf.tick) begin
      dispGap <= 32'h0;
    end else begin
      dispGap <= dispGap + 32'h1;
    end
  end

  AST_OPEN_EDGE: assert property (
    (s_q.cap == CAP_ARMED) && active && !s_q.ctrl[CTRL_CLOSE] && detFall
    |=> captureFrozen && $fell(s_q.detLvl) || !active)
    else $error("open-type capture missed a falling detect edge");

  AST_CLOSE_EDGE: assert property (
    (s_q.cap == CAP_ARMED) && active && s_q.ctrl[CTRL_CLOSE] && detRise
    |=> captureFrozen || !active)
    else $error("close-type capture missed a rising detect edge");

  AST_HOLD: assert property (
    captureFrozen && $past(captureFrozen) |-> $stable(dispValue))
    else $error("display moved while frozen");

  AST_CAPT_VAL: assert property (
    $rose(captureFrozen) |-> dispValue == $past(s_q.lastF)
                          && s_q.captF == $past(s_q.lastF))
    else $error("frozen value is not the force at the switch change");

  AST_DISABLED: assert property (
    !s_q.ctrl[CTRL_EN] |=> !captureFrozen && !open_capture_indicator
                           && !close_capture_indicator)
    else $error("capture active while contact closure disabled");

  AST_INDICATOR: assert property (
    active ##1 active |-> open_capture_indicator != close_capture_indicator
                          && close_capture_indicator == s_q.ctrl[CTRL_CLOSE])
    else $error("mode indicator does not match setup type");

  AST_PASS_FAIL: assert property (
    capEvt |=> (passFlag == ($past(s_q.ctrl[CTRL_PF]) && $past(pfOk)))
               && (failFlag == ($past(s_q.ctrl[CTRL_PF]) && !$past(pfOk))))
    else $error("pass/fail flags wrong after capture");

  AST_RESULT_STORE: assert property (
    capEvt && !memFull |=> s_q.resCnt == $past(s_q.resCnt) + RES_AW'(1)
                           && resMem[$past(s_q.resCnt)] == $past(s_q.lastF))
    else $error("captured result not stored");

  AST_DISP_RATE: assert property (
    dispGap <= DISP_SLOW_P)
    else $error("display update interval too long");

  AST_PEAK_ORDER: assert property (
    tensionPeak >= compressionPeak || $past(srst))
    else $error("tension peak below compression peak");

  AST_PEAK_RST: assert property (
    $fell(srst) |-> s_q.ctrl[CTRL_RATE_LSB +: 2] == RATE_MAX)
    else $error("peak rate not at maximum after reset");

  AST_FIRST_ONLY: assert property (
    captureFrozen && $past(captureFrozen) && !$past(wrAcc) |-> $stable(s_q.captF))
    else $error("second edge re-captured without re-arm");

  COV_OPEN: cover property (capEvt && !s_q.ctrl[CTRL_CLOSE]);
  COV_CLOSE: cover property (capEvt && s_q.ctrl[CTRL_CLOSE]);
  COV_FAIL: cover property (capEvt && s_q.ctrl[CTRL_PF] && !pfOk);
  COV_FULL: cover property (capEvt && memFull);
endmodule

// ===== bench/ccfc_switch_model.sv
module ccfc_switch_model (
  input  wire logic ref_clk,
  input  wire logic closeReq,
  output logic      detectOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // a switch moves only on rising clock edges, never mid-cycle
  initial detectOut = 1'b0;
  always @(posedge ref_clk) begin
    detectOut <= closeReq;
  end
endmodule

// ===== bench/contact_closure_force_capture_tb_top.sv
module contact_closure_force_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccfc_pkg::*;

  logic                      ref_clk    = 1'b0;
  logic                      srst       = 1'b1;
  logic                      psel       = 1'b0;
  logic                      penable    = 1'b0;
  logic                      pwrite     = 1'b0;
  logic [7:0]                paddr      = 8'h00;
  logic [31:0]               pwdata     = 32'h0;
  logic                      closeReq   = 1'b0;
  logic                      forceValid = 1'b1;
  logic signed [FORCE_W-1:0] forceIn    = 24'h0;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      detectIn;
  logic signed [FORCE_W-1:0] dispValue;
  logic signed [FORCE_W-1:0] tensionPeak;
  logic signed [FORCE_W-1:0] compressionPeak;
  logic                      captureFrozen;
  logic                      openInd;
  logic                      closeInd;
  logic                      passFlag;
  logic                      failFlag;
  logic [1:0]                unitsSel;
  logic                      irq;
  logic [31:0]               rd;
  logic                      errSeen;
  logic [15:0]               lfsrQ      = 16'h0046;
  int                        bad_count  = 0;
  int                        n_checks   = 0;
  int                        lastF;

  always #4 ref_clk = ~ref_clk;

  ccfc_switch_model sw (.ref_clk(ref_clk), .closeReq(closeReq), .detectOut(detectIn));

  ccfc_contact_capture #(
    .DISP_FAST_P(20), .PEAK_LO_P(40),
    .PEAK_MID_P(20), .PEAK_HI_P(10), .PEAK_MAX_P(4)
  ) uut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .detectIn(detectIn), .forceIn(forceIn), .forceValid(forceValid),
    .dispValue(dispValue), .tensionPeak(tensionPeak), .compressionPeak(compressionPeak),
    .captureFrozen(captureFrozen), .open_capture_indicator(openInd),
    .close_capture_indicator(closeInd), .passFlag(passFlag), .failFlag(failFlag),
    .unitsSel(unitsSel), .irq(irq)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // call just after a rising edge; returns one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // only the watchdog ends a stalled access
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic setF(input int v);
    forceIn <= FORCE_W'(v);
    lastF = v;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic waitFrozen();
    int n;
    n = 0;
    while (captureFrozen !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #400000;
    bad_count++;
    results();
  end

  // capture cases: type, nominal mode, force offset from limA (low limit or nominal), pass
  int typT[4] = '{0, 1, 0, 1};
  int nomT[4] = '{0, 0, 1, 1};
  int offT[4] = '{30, -1, -30, 31};
  int pasT[4] = '{1, 0, 1, 0};

  initial begin
    int a;
    int capt;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0c0, "ctrl after reset");
    apb(1'b0, 8'h34, 32'h0);
    check({31'h0, errSeen}, 32'h1, "unmapped access");
    apb(1'b1, ADDR_INTMSK, 32'h1);
    // mode set without enable: switch activity must not freeze
    closeReq <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h004);
    repeat (6) @(posedge ref_clk);
    closeReq <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check({30'h0, captureFrozen, openInd}, 32'h0, "frozen while disabled");
    $display("test disabled done");
    for (int i = 0; i < 4; i++) begin
      lfsrQ = lfsr(lfsrQ);
      a = int'($signed(lfsrQ[11:0]));
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_LIMA, nomT[i] ? a + 30 : a);
      apb(1'b1, ADDR_LIMB, nomT[i] ? 30 : a + 30);
      closeReq <= (typT[i] == 0);
      setF(a + (nomT[i] ? 30 : 0) + offT[i]);
      repeat (4) @(posedge ref_clk);
      apb(1'b1, ADDR_CTRL, 32'h00d | (typT[i] << 1) | (nomT[i] << 4));
      repeat (3) @(posedge ref_clk);
      check({30'h0, openInd, closeInd}, typT[i] ? 32'h1 : 32'h2, "indicator");
      check({31'h0, captureFrozen}, 32'h0, "frozen before edge");
      closeReq <= (typT[i] != 0);
      waitFrozen();
      capt = lastF;
      check({31'h0, captureFrozen}, 32'h1, "capture on edge");
      check(dispValue, capt, "frozen value");
      lfsrQ = lfsr(lfsrQ);
      setF(capt + 1 + lfsrQ[7:0]);
      closeReq <= ~closeReq;
      repeat (8) @(posedge ref_clk);
      closeReq <= ~closeReq;
      repeat (8) @(posedge ref_clk);
      check(dispValue, capt, "held after later edges");
      check({30'h0, passFlag, failFlag}, pasT[i] ? 32'h2 : 32'h1, "pass fail");
      apb(1'b0, ADDR_CAPT, 32'h0);
      check(rd, capt, "stored capture");
      apb(1'b0, ADDR_STATUS, 32'h0);
      check({25'h0, rd[14:8]}, i + 1, "result count");
      apb(1'b1, ADDR_RESIDX, i);
      apb(1'b0, ADDR_RESDATA, 32'h0);
      check(rd, capt & 32'h00ffffff, "stored result");
      check({31'h0, irq}, 32'h1, "capture interrupt");
      apb(1'b1, ADDR_INTST, 32'h3);
      check({31'h0, irq}, 32'h0, "interrupt cleared");
      $display("test capture %0d done", i);
    end
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ADDR_CTRL, 32'h001 | (r << 6) | (r << 8));
      check({30'h0, unitsSel}, r, "units");
      lfsrQ = lfsr(lfsrQ);
      a = 100 + lfsrQ[9:0];
      // two peak ticks first, so the old force is gone before the clear
      setF(a);
      repeat (100) @(posedge ref_clk);
      apb(1'b1, ADDR_CMD, 32'h2);
      repeat (200) @(posedge ref_clk);
      check(tensionPeak, a, "tension peak");
      setF(-a);
      repeat (300) @(posedge ref_clk);
      check(compressionPeak, -a, "compression peak");
      check(tensionPeak, a, "tension kept");
      check({31'h0, dispValue[FORCE_W-1]}, 32'h1, "display follows force");
      $display("test peak rate %0d done", r);
    end
    results();
  end
endmodule
